// File: src/aicfg_defs.vh
// Register offsets, field positions and reset values for the analog input configuration block
`ifndef AICFG_DEFS_VH
`define AICFG_DEFS_VH
`define CFG_INDEX 8'h20
`define CFG_ADDR 12'h080
`define POL_ADDR 12'h084
`define STAT_ADDR 12'h088
`define CFG_RESET 16'h0000
`define CFG_MASK 16'h07FF
`define F_SRC_LO 0
`define F_SRC_HI 3
`define F_GATE 4
`define F_CNT_SYNC 5
`define F_TMR_SYNC 6
`define F_AVG_INV 7
`define F_SIGN_LO 8
`define F_SIGN_HI 9
`define F_FORMAT 10
`define SRC_LEGACY 4'h0
`define SRC_TIMER 4'h1
`define SRC_THRESH 4'h2
`define TC_MIN 16'h8000
`define TC_MIN_SAT 16'h8001
`endif

// File: src/result_formatter.v
// Converts one raw straight-binary result to the selected output encoding
`timescale 1ns/100ps
module result_formatter (
   // Control
   input wire number_format_select,
   input wire [1:0] sign_handling_select,
   input wire channel_polarity_bit,
   // Data
   input wire [15:0] raw_result,
   output reg [15:0] formatted_result
);
`include "aicfg_defs.vh"
   reg [15:0] tc;
   reg [15:0] neg;
   reg [15:0] mag;
   always @* begin
      tc = raw_result ^ `TC_MIN;
      neg = (tc == `TC_MIN) ? 16'h7FFF : (~tc + 16'h0001);
      mag = tc[15] ? neg : tc;
      formatted_result = raw_result;
      if (!number_format_select) begin
         if (sign_handling_select[0] && channel_polarity_bit) begin
            formatted_result = ~raw_result;
         end
      end else if (sign_handling_select[1]) begin
         // Polarity set reports the magnitude as a non-positive number
         formatted_result = channel_polarity_bit ? (~mag + 16'h0001) : mag;
      end else if (sign_handling_select[0]) begin
         // Most negative code is clipped so negation stays in range
         formatted_result = channel_polarity_bit ? neg : ((tc == `TC_MIN) ? `TC_MIN_SAT : tc);
      end else begin
         formatted_result = tc;
      end
   end
endmodule // result_formatter

// File: src/sample_pacer.v
// Sample/frame timer and counter with trigger alignment
`timescale 1ns/100ps
module sample_pacer #(
   parameter TW = 16
) (
   // Clock and reset
   input wire hclk,
   input wire hresetn,
   // Control
   input wire timer_sync,
   input wire counter_sync,
   input wire trigger_start,
   input wire [TW-1:0] interval,
   // Status
   output reg timer_tick_ff,
   output reg [TW-1:0] frame_count_ff
);
   reg [TW-1:0] timer_ff;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timer_ff <= {TW{1'b0}};
         timer_tick_ff <= 1'b0;
         frame_count_ff <= {TW{1'b0}};
      end else begin
         if (trigger_start && timer_sync) begin
            // Restart so the first sample lands right after the trigger
            timer_ff <= {TW{1'b0}};
            timer_tick_ff <= 1'b1;
         end else if (timer_ff >= interval) begin
            timer_ff <= {TW{1'b0}};
            timer_tick_ff <= 1'b1;
         end else begin
            timer_ff <= timer_ff + {{(TW-1){1'b0}}, 1'b1};
            timer_tick_ff <= 1'b0;
         end
         if (trigger_start && counter_sync) begin
            frame_count_ff <= {TW{1'b0}};
         end else if (timer_tick_ff) begin
            frame_count_ff <= frame_count_ff + {{(TW-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule // sample_pacer

// File: src/ai_general_config.v
// Analog input general configuration: register, result formatting, sample control
// Function
// - Format clear gives straight binary, 0x0000 most negative, 0xFFFF most positive.
// - Format set gives two's complement, 0x8000 to 0x7FFF.
// - Binary with sign bit0 clear ignores polarity; reset behaviour.
// - Binary with sign bit0 set inverts scale for polarity-set channels.
// - Two's complement with sign handling 00 ignores polarity.
// - Setting 01 negates polarity-set channels, never outputs 0x8000.
// - Sign bit1 set in two's complement outputs absolute value, negated for polarity-set channels.
// - Averaging invert flips jumper; effective state readable as status bit.
// - Timer sync clears sample/frame timer at trigger start.
// - Counter sync clears sample/frame counter at trigger start.
// - Gate bit clear ignores trigger subsystem; set gates sampling by it.
// - Four-bit sample source select, default 0000.
// - Source 0000 legacy, 0001 frame timer, 0010 threshold counter.
`timescale 1ns/100ps
module ai_general_config #(
   parameter CH = 16,
   parameter TW = 16
) (
   // AHB-Lite
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [11:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   // Converter side
   input wire [15:0] raw_result,
   input wire [3:0] raw_channel,
   input wire raw_valid,
   output reg [15:0] result_ff,
   output reg [3:0] result_channel_ff,
   output reg result_valid_ff,
   // Averaging jumper
   input wire averaging_jumper,
   output reg averaging_jumper_state,
   // Trigger and sampling sources
   input wire trigger_start,
   input wire trigger_gate,
   input wire [1:0] legacy_source_select,
   input wire legacy_sample,
   input wire threshold_count_sample,
   input wire [TW-1:0] timer_interval,
   output reg sample_request_ff,
   output reg [TW-1:0] frame_count
);
`include "aicfg_defs.vh"
   reg [15:0] cfg_ff;
   reg [CH-1:0] polarity_ff;
   reg wr_pend_ff;
   reg rd_pend_ff;
   reg [11:0] addr_ff;
   wire [15:0] fmt_result;
   wire timer_tick;
   wire [TW-1:0] frame_count_w;
   reg src_pulse;
   reg [31:0] nxt_hrdata;
   reg [CH-1:0] polarity_ff_sel;
   wire addr_phase;

   assign addr_phase = hsel && hready && htrans[1];

   // Map a sampling-source code to its pulse
   function src_decode;
      input [3:0] sel;
      input leg;
      input tmr;
      input thr;
      begin
         case (sel)
            `SRC_LEGACY: src_decode = leg;
            `SRC_TIMER: src_decode = tmr;
            `SRC_THRESH: src_decode = thr;
            default: src_decode = 1'b0;
         endcase
      end
   endfunction

   // Zero-wait bus: answer in the data phase following the address phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff <= 1'b0;
         rd_pend_ff <= 1'b0;
         addr_ff <= 12'h000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h00000000;
      end else begin
         wr_pend_ff <= addr_phase && hwrite;
         rd_pend_ff <= addr_phase && !hwrite;
         if (addr_phase) begin
            addr_ff <= haddr;
         end
         hrdata <= nxt_hrdata;
      end
   end

   // Read data is registered during the address phase so it stands in the data phase
   always @* begin
      nxt_hrdata = 32'h00000000;
      if (addr_phase && !hwrite) begin
         case (haddr)
            `CFG_ADDR: nxt_hrdata = {16'h0000, cfg_ff};
            `POL_ADDR: nxt_hrdata = {{(32-CH){1'b0}}, polarity_ff};
            `STAT_ADDR: nxt_hrdata = {31'h00000000, averaging_jumper_state};
            default: nxt_hrdata = 32'h00000000;
         endcase
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_ff <= `CFG_RESET;
         polarity_ff <= {CH{1'b0}};
      end else if (wr_pend_ff) begin
         if (addr_ff == `CFG_ADDR) begin
            cfg_ff <= hwdata[15:0] & `CFG_MASK;
         end
         if (addr_ff == `POL_ADDR) begin
            polarity_ff <= hwdata[CH-1:0];
         end
      end
   end

   always @* begin
      polarity_ff_sel = polarity_ff >> raw_channel;
   end

   result_formatter u_fmt (
      .number_format_select(cfg_ff[`F_FORMAT]),
      .sign_handling_select(cfg_ff[`F_SIGN_HI:`F_SIGN_LO]),
      .channel_polarity_bit(polarity_ff_sel[0]),
      .raw_result(raw_result),
      .formatted_result(fmt_result)
   );

   sample_pacer #(.TW(TW)) u_pacer (
      .hclk(hclk),
      .hresetn(hresetn),
      .timer_sync(cfg_ff[`F_TMR_SYNC]),
      .counter_sync(cfg_ff[`F_CNT_SYNC]),
      .trigger_start(trigger_start),
      .interval(timer_interval),
      .timer_tick_ff(timer_tick),
      .frame_count_ff(frame_count_w)
   );

   always @* begin
      src_pulse = src_decode(cfg_ff[`F_SRC_HI:`F_SRC_LO], legacy_sample,
                             timer_tick, threshold_count_sample);
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         result_ff <= 16'h0000;
         result_channel_ff <= 4'h0;
         result_valid_ff <= 1'b0;
         averaging_jumper_state <= 1'b0;
         sample_request_ff <= 1'b0;
         frame_count <= {TW{1'b0}};
      end else begin
         // Only formatted data leaves the block; in straight binary without inversion it equals the raw code
         result_valid_ff <= raw_valid;
         if (raw_valid) begin
            result_ff <= fmt_result;
            result_channel_ff <= raw_channel;
         end
         averaging_jumper_state <= averaging_jumper ^ cfg_ff[`F_AVG_INV];
         // Gate ignored unless trigger-gated sampling is selected
         sample_request_ff <= src_pulse && (!cfg_ff[`F_GATE] || trigger_gate);
         frame_count <= frame_count_w;
      end
   end
   // legacy_source_select is consumed by the downstream legacy pacer
   wire unused_legacy;
   assign unused_legacy = ^legacy_source_select;
endmodule // ai_general_config

// File: bench/ai_general_config_asserts.sv
// Checker for the analog input general configuration block
`timescale 1ns/100ps
`include "aicfg_defs.vh"
module ai_general_config_asserts #(
   parameter CH = 16,
   parameter TW = 16
) (
   // Bus
   input logic hclk, hresetn, hsel, hwrite, hready,
   input logic [1:0] htrans,
   input logic [11:0] haddr,
   input logic [31:0] hwdata,
   // Data path and sampling
   input logic raw_valid, result_valid_ff, averaging_jumper, averaging_jumper_state,
   input logic trigger_start, trigger_gate, sample_request_ff,
   input logic [15:0] raw_result, result_ff,
   input logic [3:0] raw_channel, result_channel_ff
);
   // Shadow copies, since the checker may not look inside
   logic wc_ff, wp_ff;
   logic [15:0] cfg_ff, pol_ff;
   wire pol = pol_ff[raw_channel];
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wc_ff <= 1'h0;
         wp_ff <= 1'h0;
         cfg_ff <= `CFG_RESET;
         pol_ff <= 16'h0000;
      end else begin
         wc_ff <= hsel && hready && htrans[1] && hwrite && haddr == `CFG_ADDR;
         wp_ff <= hsel && hready && htrans[1] && hwrite && haddr == `POL_ADDR;
         if (wc_ff) cfg_ff <= hwdata[15:0] & `CFG_MASK;
         if (wp_ff) pol_ff <= hwdata[15:0];
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_fmt_plain: assert property (raw_valid && cfg_ff[10:8] == 3'h0
      |=> result_ff == $past(raw_result)) else $error("plain code");
   a_fmt_twos: assert property (raw_valid && cfg_ff[10:8] == 3'h4
      |=> result_ff == ($past(raw_result) ^ 16'h8000)) else $error("twos code");
   a_no_min: assert property (raw_valid && cfg_ff[10:8] == 3'h5
      |=> result_ff != `TC_MIN) else $error("minimum code");
   a_abs_sign: assert property (raw_valid && cfg_ff[10:9] == 2'h3
      |=> result_ff[15] == ($past(pol) && result_ff != 16'h0000)) else $error("abs sign");
   a_out_lag: assert property (raw_valid
      |=> result_valid_ff && result_channel_ff == $past(raw_channel)) else $error("lag");
   a_jumper_flip: assert property ($changed(averaging_jumper) && $stable(cfg_ff[7])
      |=> $changed(averaging_jumper_state)) else $error("jumper state");
   a_sync_tick: assert property (trigger_start && cfg_ff[6] && cfg_ff[4:0] == 5'h01
      |-> ##[1:2] sample_request_ff) else $error("no synced sample");
   a_gate_shut: assert property ((cfg_ff[4] && !trigger_gate) [*3]
      |-> !sample_request_ff) else $error("gated sample");
   c_abs: cover property (raw_valid && cfg_ff[10:9] == 2'h3 && pol);
   c_sync: cover property (trigger_start && cfg_ff[6]);
   c_gate: cover property (cfg_ff[4] && sample_request_ff);
endmodule // ai_general_config_asserts
bind ai_general_config ai_general_config_asserts #(.CH(CH), .TW(TW)) chk_inst (.*);

// File: bench/ai_general_config_tb.sv
// Bench for the analog input general configuration block
`timescale 1ns/100ps
`include "aicfg_defs.vh"
module ai_general_config_tb;
   logic hclk = '0, hresetn = '0, hsel = '0, hwrite = '0, hready = '1, raw_valid = '0;
   logic averaging_jumper = '0, trigger_start = '0, trigger_gate = '0, hreadyout, hresp;
   logic legacy_sample = '0, threshold_count_sample = '0, result_valid_ff;
   logic averaging_jumper_state, sample_request_ff;
   logic [1:0] htrans = '0, legacy_source_select = '0;
   logic [2:0] hsize = 3'h2;
   logic [3:0] raw_channel = '0, result_channel_ff;
   logic [11:0] haddr = '0;
   logic [15:0] raw_result = '0, timer_interval = 16'h0009, result_ff, frame_count, cfg, pol;
   logic [31:0] hwdata = '0, hrdata, rd;
   int n_mismatch = 0, num_checks = 0, hits;
   always #50 hclk = ~hclk;
   ai_general_config ai_general_config_inst (.*);
   function automatic logic [15:0] fmt(input logic [15:0] r, input logic p);
      logic [15:0] c;
      c = r ^ 16'h8000;
      if (!cfg[10]) return (cfg[8] && p) ? ~r : r;
      if (cfg[9:8] == 2'h0) return c;
      if (c == `TC_MIN) c = `TC_MIN_SAT;
      if (cfg[9] && c[15]) c = -c;
      return p ? -c : c;
   endfunction
   task automatic chk(input logic [31:0] got, exp, input string what);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // The one slave answers at once, but the wait stays open-ended
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'h1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      rd = hrdata;
      chk(hresp, 1'h0, "response");
   endtask
   task automatic conv(input logic [15:0] r, input logic [3:0] c);
      raw_result <= r;
      raw_channel <= c;
      raw_valid <= 1'h1;
      @(posedge hclk);
      raw_valid <= 1'h0;
      // Look at the falling edge, where the registered result has settled
      @(negedge hclk);
      chk(result_ff, fmt(r, pol[c]), "result");
      chk({result_valid_ff, result_channel_ff}, {1'h1, c}, "channel");
      @(posedge hclk);
   endtask
   // Settle first, so pulses of the previous source stay out of the window
   task automatic count(input int exp);
      hits = 0;
      repeat (4) @(posedge hclk);
      for (int k = 0; k < 40; k++) begin
         legacy_sample <= (k % 5 == 0);
         threshold_count_sample <= (k % 5 == 0);
         @(posedge hclk);
         hits += sample_request_ff;
      end
      chk(hits, exp, "requests");
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (6000) @(posedge hclk);
      n_mismatch++;
      print_verdict();
   end
   initial begin
      void'($urandom(52028));
      repeat (4) @(posedge hclk);
      hresetn <= 1'h1;
      @(posedge hclk);
      bus(1'h0, `CFG_ADDR, '0);
      chk(rd, `CFG_RESET, "reset");
      bus(1'h1, 12'hFFC, 32'hFFFFFFFF);
      bus(1'h0, 12'hFFC, '0);
      chk(rd, '0, "unmapped");
      for (int m = 0; m < 8; m++) begin
         cfg = {5'h00, m[2:0], 8'h00};
         pol = $urandom;
         bus(1'h1, `CFG_ADDR, cfg);
         bus(1'h1, `POL_ADDR, pol);
         for (int i = 0; i < 12; i++)
            conv(i == 0 ? 16'h0000 : i == 1 ? 16'hFFFF : i == 2 ? 16'h8001 : $urandom, $urandom);
      end
      for (int j = 0; j < 4; j++) begin
         bus(1'h1, `CFG_ADDR, {j[1], 7'h00});
         averaging_jumper <= j[0];
         repeat (2) @(posedge hclk);
         bus(1'h0, `STAT_ADDR, '0);
         chk(rd, j[0] ^ j[1], "jumper");
      end
      for (int s = 0; s < 16; s++) begin
         bus(1'h1, `CFG_ADDR, s);
         count(s == 1 ? 4 : (s == 0 || s == 2) ? 8 : 0);
      end
      bus(1'h1, `CFG_ADDR, 32'h00000011);
      count(0);
      trigger_gate <= 1'h1;
      count(4);
      bus(1'h1, `CFG_ADDR, 32'h00000061);
      do @(posedge hclk); while (sample_request_ff !== 1'h1);
      hits = 0;
      for (int k = 0; k < 9; k++) begin
         trigger_start <= (k == 1 || k == 5);
         @(posedge hclk);
         hits += sample_request_ff;
      end
      chk(hits, 2, "synced");
      chk(frame_count < 16'h0003, 1'h1, "frame count");
      print_verdict();
   end
endmodule // ai_general_config_tb
